//--- hw/bbcc_pkg.sv
// Purpose: Shared constants and types for the bit-branch and CPU-control execution unit.
// Assumes: One clock at 100 MHz; every count here is in CPU clock cycles.
// Notes: Packed tables are indexed by operand area, lowest area in the lowest slot.
// Functional notes
// - One counted cycle is one CPU clock period; counts assume fetch from internal ROM.
// - Second cycle column applies when the operand lies outside high-speed RAM.
// - Branch if set, short direct bit: 3 bytes, 8 or 9 cycles.
// - Branch if set, special register bit: 4 bytes, 11 cycles.
// - Branch if set, accumulator bit: 3 bytes, 8 cycles.
// - Branch if set, status word bit: 3 bytes, 9 cycles.
// - Branch if set, bit of byte at HL: 3 bytes, 10 or 11 cycles.
// - Branch if clear, short direct bit: 4 bytes, 10 or 11 cycles.
// - Branch if clear, special register bit: 4 bytes, 11 cycles.
// - Branch if clear, accumulator bit: 3 bytes, 8 cycles.
// - Branch if clear, status word bit: 4 bytes, 11 cycles.
// - Branch if clear, bit of byte at HL: 3 bytes, 10 or 11 cycles.
// - Branch and clear, short direct bit: 4 bytes, 10 or 12 cycles, clears bit.
// - Branch and clear, special register bit: 4 bytes, 12 cycles, clears bit.
// - Branch and clear, accumulator bit: 3 bytes, 8 cycles, clears bit.
// - Branch and clear, status word bit: 4 bytes, 12 cycles; flags may change.
// - Branch and clear, bit at HL: 3 bytes, 10 or 12 cycles, clears bit.
// - Decrement B or C, branch if nonzero: 2 bytes, 6 cycles.
// - Decrement short direct byte, branch if nonzero: 3 bytes, 8 or 10 cycles.
// - Interrupt enable op sets the global enable: 2 bytes, 6 cycles.
// - Interrupt disable op clears the global enable: 2 bytes, 6 cycles.
package bbcc_pkg;

  typedef enum logic [3:0] {
    BBCC_OP_BIT_SET   = 4'h0,
    BBCC_OP_BIT_CLEAR = 4'h1,
    BBCC_OP_BIT_CLR   = 4'h2,
    BBCC_OP_DEC_BR    = 4'h3,
    BBCC_OP_EI        = 4'h4,
    BBCC_OP_DI        = 4'h5,
    BBCC_OP_SEL_BANK  = 4'h6,
    BBCC_OP_NOP       = 4'h7,
    BBCC_OP_HALT      = 4'h8,
    BBCC_OP_STOP      = 4'h9
  } bbcc_op_type;

  typedef enum logic [2:0] {
    BBCC_AREA_SADDR = 3'h0,
    BBCC_AREA_SFR   = 3'h1,
    BBCC_AREA_ACC   = 3'h2,
    BBCC_AREA_PSW   = 3'h3,
    BBCC_AREA_HL    = 3'h4,
    BBCC_AREA_REG_B = 3'h5,
    BBCC_AREA_REG_C = 3'h6
  } bbcc_area_type;

  typedef enum logic [1:0] {
    BBCC_IDLE = 2'b01,
    BBCC_RUN  = 2'b10
  } bbcc_fsm_type;

  // Slots ordered {hl, psw, acc, sfr, saddr}.
  localparam logic [4:0][2:0] LEN_BIT_SET   = {3'h3, 3'h3, 3'h3, 3'h4, 3'h3};
  localparam logic [4:0][3:0] CYC_BIT_SET_H = {4'ha, 4'h9, 4'h8, 4'hb, 4'h8};
  localparam logic [4:0][3:0] CYC_BIT_SET_X = {4'hb, 4'h9, 4'h8, 4'hb, 4'h9};
  localparam logic [4:0][2:0] LEN_BIT_CLEAR = {3'h3, 3'h4, 3'h3, 3'h4, 3'h4};
  localparam logic [4:0][3:0] CYC_BIT_CLR_H = {4'ha, 4'hb, 4'h8, 4'hb, 4'ha};
  localparam logic [4:0][3:0] CYC_BIT_CLR_X = {4'hb, 4'hb, 4'h8, 4'hb, 4'hb};
  localparam logic [4:0][2:0] LEN_BIT_CLR   = {3'h3, 3'h4, 3'h3, 3'h4, 3'h4};
  localparam logic [4:0][3:0] CYC_CLR_BR_H  = {4'ha, 4'hc, 4'h8, 4'hc, 4'ha};
  localparam logic [4:0][3:0] CYC_CLR_BR_X  = {4'hc, 4'hc, 4'h8, 4'hc, 4'hc};

  localparam logic [2:0] LEN_DEC_REG      = 3'h2;
  localparam logic [3:0] CYC_DEC_REG      = 4'h6;
  localparam logic [2:0] LEN_DEC_SADDR    = 3'h3;
  localparam logic [3:0] CYC_DEC_SADDR_H  = 4'h8;
  localparam logic [3:0] CYC_DEC_SADDR_X  = 4'ha;
  localparam logic [2:0] LEN_CONTROL      = 3'h2;
  localparam logic [3:0] CYC_INT_ENABLE   = 4'h6;
  localparam logic [3:0] CYC_SEL_BANK     = 4'h4;
  localparam logic [3:0] CYC_STANDBY      = 4'h6;
  localparam logic [2:0] LEN_NOP          = 3'h1;
  localparam logic [3:0] CYC_NOP          = 4'h2;

  localparam logic       RST_INT_ENABLE   = 1'b0;
  localparam logic [1:0] RST_BANK         = 2'h0;

endpackage

//--- hw/bbcc_timing.sv
// Purpose: Instruction length and cycle count for each operation and operand area.
// Assumes: Inputs come from the same clock domain; the result is purely combinational.
// Notes: Illegal pairs of operation and area report legal_o low.
module bbcc_timing
  import bbcc_pkg::*;
(
  input  wire bbcc_op_type   op_i,
  input  wire bbcc_area_type area_i,
  input  wire logic          hs_ram_i,
  output logic [2:0]         len_o,
  output logic [3:0]         cyc_o,
  output logic               legal_o
);

  logic       bit_area;
  logic [2:0] slot;

  assign bit_area = (area_i <= BBCC_AREA_HL);
  assign slot     = bit_area ? area_i : 3'h0;

  // The high-speed RAM column applies only to short direct and HL operands.
  always_comb begin
    len_o   = LEN_NOP;
    cyc_o   = CYC_NOP;
    legal_o = 1'b1;
    case (op_i)
      BBCC_OP_BIT_SET: begin
        len_o   = LEN_BIT_SET[slot];
        cyc_o   = hs_ram_i ? CYC_BIT_SET_H[slot] : CYC_BIT_SET_X[slot];
        legal_o = bit_area;
      end
      BBCC_OP_BIT_CLEAR: begin
        len_o   = LEN_BIT_CLEAR[slot];
        cyc_o   = hs_ram_i ? CYC_BIT_CLR_H[slot] : CYC_BIT_CLR_X[slot];
        legal_o = bit_area;
      end
      BBCC_OP_BIT_CLR: begin
        len_o   = LEN_BIT_CLR[slot];
        cyc_o   = hs_ram_i ? CYC_CLR_BR_H[slot] : CYC_CLR_BR_X[slot];
        legal_o = bit_area;
      end
      BBCC_OP_DEC_BR: begin
        if (area_i == BBCC_AREA_SADDR) begin
          len_o = LEN_DEC_SADDR;
          cyc_o = hs_ram_i ? CYC_DEC_SADDR_H : CYC_DEC_SADDR_X;
        end else begin
          len_o   = LEN_DEC_REG;
          cyc_o   = CYC_DEC_REG;
          legal_o = (area_i == BBCC_AREA_REG_B) || (area_i == BBCC_AREA_REG_C);
        end
      end
      BBCC_OP_EI, BBCC_OP_DI: begin
        len_o = LEN_CONTROL;
        cyc_o = CYC_INT_ENABLE;
      end
      BBCC_OP_SEL_BANK: begin
        len_o = LEN_CONTROL;
        cyc_o = CYC_SEL_BANK;
      end
      BBCC_OP_HALT, BBCC_OP_STOP: begin
        len_o = LEN_CONTROL;
        cyc_o = CYC_STANDBY;
      end
      BBCC_OP_NOP: begin
        len_o = LEN_NOP;
        cyc_o = CYC_NOP;
      end
      default: begin
        legal_o = 1'b0;
      end
    endcase
  end

endmodule

//--- hw/bbcc_exec.sv
// Purpose: Executes bit-test branches, decrement loops and CPU control operations.
// Assumes: Decoded operation, operand byte and program counter arrive on the same clock.
// Notes: Results appear together with done_o after the documented number of cycles.
module bbcc_exec
  import bbcc_pkg::*;
#(
  parameter int PC_W = 16
)
(
  input  wire logic          clock_i,
  input  wire logic          reset_n_i,
  input  wire logic          start_i,
  input  wire bbcc_op_type   op_i,
  input  wire bbcc_area_type area_i,
  input  wire logic [2:0]    bit_sel_i,
  input  wire logic [7:0]    signed_branch_offset_i,
  input  wire logic [PC_W-1:0] pc_i,
  input  wire logic [7:0]    operand_i,
  input  wire logic          hs_ram_i,
  input  wire logic [1:0]    bank_i,
  output logic               busy_o,
  output logic               done_o,
  output logic               illegal_o,
  output logic               taken_o,
  output logic [PC_W-1:0]    pc_o,
  output logic               wr_en_o,
  output logic [2:0]         wr_area_o,
  output logic [7:0]         wr_data_o,
  output logic               global_interrupt_enable_o,
  output logic [1:0]         bank_select_bits_o,
  output logic               halt_o,
  output logic               stop_o
);

  if (PC_W < 8) begin : g_bad_width
    $error("PC_W must be at least 8 bits.");
  end

  typedef struct packed {
    bbcc_fsm_type       fsm;
    logic [3:0]         cnt;
    bbcc_op_type        op;
    logic [1:0]         bank_req;
    logic [PC_W-1:0]    p_pc;
    logic               p_taken;
    logic               p_wr_en;
    logic [7:0]         p_wr_data;
    logic [2:0]         p_area;
    logic               done;
    logic               illegal;
    logic               taken;
    logic [PC_W-1:0]    pc;
    logic               wr_en;
    logic [2:0]         wr_area;
    logic [7:0]         wr_data;
    logic               ie;
    logic [1:0]         bank;
    logic               halt;
    logic               stop;
  } bbcc_state_type;

  bbcc_state_type st_r;
  bbcc_state_type st_nxt;

  logic [2:0] len;
  logic [3:0] cyc;
  logic       legal;
  logic       accept;
  logic       bit_val;
  logic [7:0] dec_val;

  bbcc_timing u_timing (
    .op_i     (op_i),
    .area_i   (area_i),
    .hs_ram_i (hs_ram_i),
    .len_o    (len),
    .cyc_o    (cyc),
    .legal_o  (legal)
  );

  // Target is the address after this instruction plus the sign-extended offset.
  function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] pc, input logic [2:0] n,
                                              input logic [7:0] disp, input logic take);
    logic [PC_W-1:0] seq;
    seq = pc + PC_W'(n);
    next_pc = take ? seq + {{(PC_W-8){disp[7]}}, disp} : seq;
  endfunction

  function automatic logic [7:0] clear_bit(input logic [7:0] v, input logic [2:0] b);
    clear_bit = v & ~(8'h01 << b);
  endfunction

  assign accept  = (st_r.fsm == BBCC_IDLE) && start_i && legal;
  assign bit_val = operand_i[bit_sel_i];
  assign dec_val = operand_i - 8'h01;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.done    = 1'b0;
    st_nxt.illegal = 1'b0;
    st_nxt.wr_en   = 1'b0;
    st_nxt.halt    = 1'b0;
    st_nxt.stop    = 1'b0;
    case (st_r.fsm)
      BBCC_IDLE: begin
        if (start_i && !legal) begin
          st_nxt.illegal = 1'b1;
        end else if (accept) begin
          st_nxt.fsm       = BBCC_RUN;
          st_nxt.cnt       = cyc - 4'h1;
          st_nxt.op        = op_i;
          st_nxt.bank_req  = bank_i;
          st_nxt.p_area    = area_i;
          st_nxt.p_taken   = 1'b0;
          st_nxt.p_wr_en   = 1'b0;
          st_nxt.p_wr_data = operand_i;
          case (op_i)
            BBCC_OP_BIT_SET: begin
              st_nxt.p_taken = bit_val;
            end
            BBCC_OP_BIT_CLEAR: begin
              st_nxt.p_taken = !bit_val;
            end
            BBCC_OP_BIT_CLR: begin
              // Writing the status word back may change its zero and carry flags.
              st_nxt.p_taken   = bit_val;
              st_nxt.p_wr_en   = bit_val;
              st_nxt.p_wr_data = clear_bit(operand_i, bit_sel_i);
            end
            BBCC_OP_DEC_BR: begin
              st_nxt.p_taken   = (dec_val != 8'h00);
              st_nxt.p_wr_en   = 1'b1;
              st_nxt.p_wr_data = dec_val;
            end
            default: begin
              st_nxt.p_taken = 1'b0;
            end
          endcase
          st_nxt.p_pc = next_pc(pc_i, len, signed_branch_offset_i, st_nxt.p_taken);
        end
      end
      BBCC_RUN: begin
        if (st_r.cnt == 4'h1) begin
          st_nxt.fsm     = BBCC_IDLE;
          st_nxt.done    = 1'b1;
          st_nxt.taken   = st_r.p_taken;
          st_nxt.pc      = st_r.p_pc;
          st_nxt.wr_en   = st_r.p_wr_en;
          st_nxt.wr_area = st_r.p_area;
          st_nxt.wr_data = st_r.p_wr_data;
          case (st_r.op)
            BBCC_OP_EI:       st_nxt.ie   = 1'b1;
            BBCC_OP_DI:       st_nxt.ie   = 1'b0;
            BBCC_OP_SEL_BANK: st_nxt.bank = st_r.bank_req;
            BBCC_OP_HALT:     st_nxt.halt = 1'b1;
            BBCC_OP_STOP:     st_nxt.stop = 1'b1;
            default:          st_nxt.ie   = st_r.ie;
          endcase
        end else begin
          st_nxt.cnt = st_r.cnt - 4'h1;
        end
      end
      default: begin
        st_nxt.fsm = BBCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r      <= '0;
      st_r.fsm  <= BBCC_IDLE;
      st_r.op   <= BBCC_OP_NOP;
      st_r.ie   <= RST_INT_ENABLE;
      st_r.bank <= RST_BANK;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o                    = st_r.fsm[1];
  assign done_o                    = st_r.done;
  assign illegal_o                 = st_r.illegal;
  assign taken_o                   = st_r.taken;
  assign pc_o                      = st_r.pc;
  assign wr_en_o                   = st_r.wr_en;
  assign wr_area_o                 = st_r.wr_area;
  assign wr_data_o                 = st_r.wr_data;
  assign global_interrupt_enable_o = st_r.ie;
  assign bank_select_bits_o        = st_r.bank;
  assign halt_o                    = st_r.halt;
  assign stop_o                    = st_r.stop;

  // Checks on the timing and results of accepted instructions.
  sequence s_accept;
    accept;
  endsequence

  sequence s_run_then_done;
    busy_o && !done_o ##1 (busy_o || done_o);
  endsequence

  property p_busy_after_accept;
    @(posedge clock_i) disable iff (!reset_n_i)
      s_accept |=> s_run_then_done;
  endproperty
  a_busy_after_accept: assert property (p_busy_after_accept) else $error("Busy missing after accept.");

  property p_bit_saddr_fast;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_BIT_SET && area_i == BBCC_AREA_SADDR && hs_ram_i
      |-> ##1 !done_o[*7] ##1 done_o;
  endproperty
  a_bit_saddr_fast: assert property (p_bit_saddr_fast) else $error("Fast short bit test timing.");

  property p_bit_saddr_slow;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_BIT_SET && area_i == BBCC_AREA_SADDR && !hs_ram_i
      |-> ##8 !done_o ##1 done_o;
  endproperty
  a_bit_saddr_slow: assert property (p_bit_saddr_slow) else $error("Slow short bit test timing.");

  property p_bit_acc_target;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_BIT_SET && area_i == BBCC_AREA_ACC && bit_val
      |-> ##8 done_o && taken_o
          && pc_o == $past(pc_i, 8) + PC_W'(3) + {{(PC_W-8){$past(signed_branch_offset_i[7], 8)}},
                                                  $past(signed_branch_offset_i, 8)};
  endproperty
  a_bit_acc_target: assert property (p_bit_acc_target) else $error("Accumulator branch target wrong.");

  property p_clear_psw;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_BIT_CLR && area_i == BBCC_AREA_PSW && bit_val
      |-> ##12 done_o && wr_en_o && !wr_data_o[$past(bit_sel_i, 12)];
  endproperty
  a_clear_psw: assert property (p_clear_psw) else $error("Status bit not cleared on time.");

  property p_dec_reg;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_DEC_BR && area_i == BBCC_AREA_REG_B
      |-> ##6 done_o && wr_data_o == $past(operand_i, 6) - 8'h01
          && taken_o == ($past(operand_i, 6) != 8'h01);
  endproperty
  a_dec_reg: assert property (p_dec_reg) else $error("Register loop result wrong.");

  property p_ei;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_EI |-> ##5 !done_o ##1 (done_o && global_interrupt_enable_o);
  endproperty
  a_ei: assert property (p_ei) else $error("Interrupt enable not set in 6 cycles.");

  property p_di;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_DI |-> ##6 done_o && !global_interrupt_enable_o;
  endproperty
  a_di: assert property (p_di) else $error("Interrupt enable not cleared in 6 cycles.");

  property p_sel_bank;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_SEL_BANK |-> ##4 done_o && bank_select_bits_o == $past(bank_i, 4);
  endproperty
  a_sel_bank: assert property (p_sel_bank) else $error("Bank select not loaded in 4 cycles.");

  property p_halt;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_HALT |-> ##6 done_o && halt_o && pc_o == $past(pc_i, 6) + PC_W'(2);
  endproperty
  a_halt: assert property (p_halt) else $error("Halt request timing or length wrong.");

  property p_bit_sfr;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_BIT_SET && area_i == BBCC_AREA_SFR |-> ##10 !done_o ##1 done_o;
  endproperty
  a_bit_sfr: assert property (p_bit_sfr) else $error("Special register bit test timing.");

  property p_bit_psw;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_BIT_SET && area_i == BBCC_AREA_PSW |-> ##8 !done_o ##1 done_o;
  endproperty
  a_bit_psw: assert property (p_bit_psw) else $error("Status word bit test timing.");

  property p_clear_hl_fast;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_BIT_CLEAR && area_i == BBCC_AREA_HL && hs_ram_i && !bit_val
      |-> ##9 !done_o ##1 (done_o && taken_o && !wr_en_o);
  endproperty
  a_clear_hl_fast: assert property (p_clear_hl_fast) else $error("Indirect clear-bit branch wrong.");

  property p_clr_acc;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_BIT_CLR && area_i == BBCC_AREA_ACC && bit_val
      |-> ##8 done_o && wr_en_o && wr_area_o == BBCC_AREA_ACC
          && wr_data_o == ($past(operand_i, 8) & ~(8'h01 << $past(bit_sel_i, 8)));
  endproperty
  a_clr_acc: assert property (p_clr_acc) else $error("Accumulator bit not cleared on time.");

  property p_dec_saddr_slow;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_DEC_BR && area_i == BBCC_AREA_SADDR && !hs_ram_i
      |-> ##9 !done_o ##1 (done_o && wr_en_o && wr_area_o == BBCC_AREA_SADDR);
  endproperty
  a_dec_saddr_slow: assert property (p_dec_saddr_slow) else $error("Short direct loop timing wrong.");

  property p_nop;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_NOP |-> ##1 !done_o ##1 (done_o && pc_o == $past(pc_i, 2) + PC_W'(1));
  endproperty
  a_nop: assert property (p_nop) else $error("No-operation timing or length wrong.");

  property p_stop;
    @(posedge clock_i) disable iff (!reset_n_i)
      accept && op_i == BBCC_OP_STOP |-> ##6 done_o && stop_o && !halt_o;
  endproperty
  a_stop: assert property (p_stop) else $error("Stop request timing wrong.");

endmodule

//--- tb/tb_bit_branch_and_cpu_control_exec.sv
// Purpose: Self-checking bench for the bit-branch and CPU-control execution unit.
// Assumes: Completion is counted from the accepting edge; outputs are sampled at the falling edge.
// Notes: Ordinary cases are table rows; refusal, back-to-back, wrap and mid-run reset are hand-written.
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, (got), (exp)); end end
module tb_bit_branch_and_cpu_control_exec
  import bbcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    bbcc_op_type   op;
    bbcc_area_type area;
    logic          hs;
    logic [2:0]    bsel;
    logic [7:0]    opnd;
    logic [2:0]    len;
    logic [3:0]    cyc;
  } bbcc_row_type;

  logic          clock_i = 1'b0;
  logic          reset_n_i = 1'b0;
  logic          start_i = 1'b0;
  bbcc_op_type   op_i = BBCC_OP_NOP;
  bbcc_area_type area_i = BBCC_AREA_ACC;
  logic [2:0]    bit_sel_i = 3'h0;
  logic [7:0]    signed_branch_offset_i = 8'h00;
  logic [15:0]   pc_i = 16'h0000;
  logic [7:0]    operand_i = 8'h00;
  logic          hs_ram_i = 1'b0;
  logic [1:0]    bank_i = 2'h0;
  logic          busy_o, done_o, illegal_o, taken_o, wr_en_o, halt_o, stop_o;
  logic          global_interrupt_enable_o;
  logic [15:0]   pc_o;
  logic [2:0]    wr_area_o;
  logic [7:0]    wr_data_o;
  logic [1:0]    bank_select_bits_o;
  int            fails = 0;
  int            samples_checked = 0;
  logic          exp_ie = 1'b0;
  logic [1:0]    exp_bank = 2'h0;
  int            n;

  bbcc_row_type rows [0:30] = '{
    '{BBCC_OP_BIT_SET,   BBCC_AREA_SADDR, 1'b1, 3'h2, 8'h04, 3'h3, 4'h8},
    '{BBCC_OP_BIT_SET,   BBCC_AREA_SADDR, 1'b0, 3'h2, 8'hfb, 3'h3, 4'h9},
    '{BBCC_OP_BIT_SET,   BBCC_AREA_SFR,   1'b0, 3'h7, 8'h80, 3'h4, 4'hb},
    '{BBCC_OP_BIT_SET,   BBCC_AREA_ACC,   1'b1, 3'h0, 8'h01, 3'h3, 4'h8},
    '{BBCC_OP_BIT_SET,   BBCC_AREA_PSW,   1'b0, 3'h6, 8'h40, 3'h3, 4'h9},
    '{BBCC_OP_BIT_SET,   BBCC_AREA_HL,    1'b1, 3'h3, 8'hf7, 3'h3, 4'ha},
    '{BBCC_OP_BIT_SET,   BBCC_AREA_HL,    1'b0, 3'h3, 8'h08, 3'h3, 4'hb},
    '{BBCC_OP_BIT_CLEAR, BBCC_AREA_SADDR, 1'b1, 3'h1, 8'hfd, 3'h4, 4'ha},
    '{BBCC_OP_BIT_CLEAR, BBCC_AREA_SADDR, 1'b0, 3'h1, 8'h02, 3'h4, 4'hb},
    '{BBCC_OP_BIT_CLEAR, BBCC_AREA_SFR,   1'b0, 3'h5, 8'h00, 3'h4, 4'hb},
    '{BBCC_OP_BIT_CLEAR, BBCC_AREA_ACC,   1'b0, 3'h4, 8'h10, 3'h3, 4'h8},
    '{BBCC_OP_BIT_CLEAR, BBCC_AREA_PSW,   1'b0, 3'h0, 8'hfe, 3'h4, 4'hb},
    '{BBCC_OP_BIT_CLEAR, BBCC_AREA_HL,    1'b1, 3'h7, 8'h7f, 3'h3, 4'ha},
    '{BBCC_OP_BIT_CLEAR, BBCC_AREA_HL,    1'b0, 3'h7, 8'h80, 3'h3, 4'hb},
    '{BBCC_OP_BIT_CLR,   BBCC_AREA_SADDR, 1'b1, 3'h5, 8'hff, 3'h4, 4'ha},
    '{BBCC_OP_BIT_CLR,   BBCC_AREA_SADDR, 1'b0, 3'h5, 8'hdf, 3'h4, 4'hc},
    '{BBCC_OP_BIT_CLR,   BBCC_AREA_SFR,   1'b0, 3'h0, 8'h81, 3'h4, 4'hc},
    '{BBCC_OP_BIT_CLR,   BBCC_AREA_ACC,   1'b1, 3'h3, 8'h0c, 3'h3, 4'h8},
    '{BBCC_OP_BIT_CLR,   BBCC_AREA_PSW,   1'b0, 3'h7, 8'hc1, 3'h4, 4'hc},
    '{BBCC_OP_BIT_CLR,   BBCC_AREA_HL,    1'b1, 3'h2, 8'h04, 3'h3, 4'ha},
    '{BBCC_OP_BIT_CLR,   BBCC_AREA_HL,    1'b0, 3'h2, 8'h3b, 3'h3, 4'hc},
    '{BBCC_OP_DEC_BR,    BBCC_AREA_REG_B, 1'b1, 3'h0, 8'h05, 3'h2, 4'h6},
    '{BBCC_OP_DEC_BR,    BBCC_AREA_REG_C, 1'b1, 3'h0, 8'h01, 3'h2, 4'h6},
    '{BBCC_OP_DEC_BR,    BBCC_AREA_SADDR, 1'b1, 3'h0, 8'h00, 3'h3, 4'h8},
    '{BBCC_OP_DEC_BR,    BBCC_AREA_SADDR, 1'b0, 3'h0, 8'h01, 3'h3, 4'ha},
    '{BBCC_OP_EI,        BBCC_AREA_ACC,   1'b0, 3'h0, 8'h00, 3'h2, 4'h6},
    '{BBCC_OP_DI,        BBCC_AREA_ACC,   1'b0, 3'h0, 8'h00, 3'h2, 4'h6},
    '{BBCC_OP_SEL_BANK,  BBCC_AREA_ACC,   1'b1, 3'h0, 8'h00, 3'h2, 4'h4},
    '{BBCC_OP_NOP,       BBCC_AREA_ACC,   1'b1, 3'h0, 8'h00, 3'h1, 4'h2},
    '{BBCC_OP_HALT,      BBCC_AREA_ACC,   1'b0, 3'h0, 8'h00, 3'h2, 4'h6},
    '{BBCC_OP_STOP,      BBCC_AREA_ACC,   1'b0, 3'h0, 8'h00, 3'h2, 4'h6}
  };

  bbcc_exec #(
    .PC_W (16)
  ) i_dut (
    .clock_i                   (clock_i),
    .reset_n_i                 (reset_n_i),
    .start_i                   (start_i),
    .op_i                      (op_i),
    .area_i                    (area_i),
    .bit_sel_i                 (bit_sel_i),
    .signed_branch_offset_i    (signed_branch_offset_i),
    .pc_i                      (pc_i),
    .operand_i                 (operand_i),
    .hs_ram_i                  (hs_ram_i),
    .bank_i                    (bank_i),
    .busy_o                    (busy_o),
    .done_o                    (done_o),
    .illegal_o                 (illegal_o),
    .taken_o                   (taken_o),
    .pc_o                      (pc_o),
    .wr_en_o                   (wr_en_o),
    .wr_area_o                 (wr_area_o),
    .wr_data_o                 (wr_data_o),
    .global_interrupt_enable_o (global_interrupt_enable_o),
    .bank_select_bits_o        (bank_select_bits_o),
    .halt_o                    (halt_o),
    .stop_o                    (stop_o)
  );

  always #5 clock_i = ~clock_i;

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Counts falling edges after the accepting edge until done_o shows; a hang ends the run.
  task automatic wait_done(output int cnt);
    bit got;
    got = 1'b0;
    cnt = 0;
    while (cnt < 20 && !got) begin
      @(negedge clock_i);
      cnt++;
      if (done_o === 1'b1)
        got = 1'b1;
    end
    if (!got) begin
      fails++;
      $display("[FAIL] %0t no completion", $time);
      final_report();
    end
  endtask

  task automatic run_row(input bbcc_row_type r, input logic [7:0] d, input logic [15:0] pc, input logic [1:0] bk);
    logic       bitv, tk, wen;
    logic [7:0] wdat;
    logic [15:0] epc;
    int         cnt;
    bitv = r.opnd[r.bsel];
    tk = (r.op == BBCC_OP_BIT_SET || r.op == BBCC_OP_BIT_CLR) ? bitv :
         (r.op == BBCC_OP_BIT_CLEAR) ? !bitv : (r.op == BBCC_OP_DEC_BR) ? (r.opnd != 8'h01) : 1'b0;
    wen = (r.op == BBCC_OP_BIT_CLR && bitv) || r.op == BBCC_OP_DEC_BR;
    wdat = (r.op == BBCC_OP_DEC_BR) ? r.opnd - 8'h01 : r.opnd & ~(8'h01 << r.bsel);
    epc = pc + 16'(r.len) + (tk ? {{8{d[7]}}, d} : 16'h0000);
    if (r.op == BBCC_OP_EI) exp_ie = 1'b1;
    if (r.op == BBCC_OP_DI) exp_ie = 1'b0;
    if (r.op == BBCC_OP_SEL_BANK) exp_bank = bk;
    @(posedge clock_i);
    start_i <= 1'b1;
    op_i <= r.op;
    area_i <= r.area;
    hs_ram_i <= r.hs;
    bit_sel_i <= r.bsel;
    operand_i <= r.opnd;
    signed_branch_offset_i <= d;
    pc_i <= pc;
    bank_i <= bk;
    @(posedge clock_i);
    start_i <= 1'b0;
    @(negedge clock_i);
    `CHECK(busy_o, 1'b1)
    wait_done(cnt);
    `CHECK(cnt + 1, int'(r.cyc))
    `CHECK(pc_o, epc)
    `CHECK(taken_o, tk)
    `CHECK(wr_en_o, wen)
    if (wen) begin
      `CHECK(wr_data_o, wdat)
      `CHECK(wr_area_o, {r.area})
    end
    `CHECK(global_interrupt_enable_o, exp_ie)
    `CHECK(bank_select_bits_o, exp_bank)
    `CHECK({halt_o, stop_o}, {r.op == BBCC_OP_HALT, r.op == BBCC_OP_STOP})
  endtask

  initial begin
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 31; i++)
      run_row(rows[i], (i % 2) ? 8'hf0 : 8'h05, 16'h1000 + 16'(i * 16), 2'(i));
    $display("table rows done");

    // An illegal pairing is refused with a one-cycle flag and never completes.
    @(posedge clock_i);
    start_i <= 1'b1;
    op_i <= BBCC_OP_BIT_SET;
    area_i <= BBCC_AREA_REG_B;
    @(posedge clock_i);
    start_i <= 1'b0;
    @(negedge clock_i);
    `CHECK({illegal_o, busy_o}, 2'b10)
    repeat (14) begin
      @(negedge clock_i);
      `CHECK({done_o, illegal_o}, 2'b00)
    end
    $display("illegal pairing done");

    // A start held during a run is ignored, then taken back to back at completion.
    @(posedge clock_i);
    start_i <= 1'b1;
    op_i <= BBCC_OP_EI;
    area_i <= BBCC_AREA_ACC;
    pc_i <= 16'h2000;
    @(posedge clock_i);
    op_i <= BBCC_OP_NOP;
    pc_i <= 16'h3000;
    wait_done(n);
    `CHECK(n, 6)
    `CHECK({pc_o, global_interrupt_enable_o}, {16'h2002, 1'b1})
    @(posedge clock_i);
    start_i <= 1'b0;
    wait_done(n);
    `CHECK(n, 2)
    `CHECK(pc_o, 16'h3001)
    $display("busy refusal and back to back done");

    // Program counter wraps at the top of the address space.
    exp_ie = 1'b1;
    run_row(rows[3], 8'h7f, 16'hfffe, 2'h0);
    run_row(rows[28], 8'h00, 16'hffff, 2'h0);
    $display("wrap done");

    // Reset in mid-run clears every output; a start right after release is served.
    @(posedge clock_i);
    start_i <= 1'b1;
    op_i <= BBCC_OP_BIT_CLR;
    area_i <= BBCC_AREA_HL;
    @(posedge clock_i);
    start_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b0;
    @(negedge clock_i);
    `CHECK({busy_o, done_o, wr_en_o, global_interrupt_enable_o, bank_select_bits_o}, 6'h00)
    `CHECK(pc_o, 16'h0000)
    @(posedge clock_i);
    reset_n_i <= 1'b1;
    exp_ie = 1'b0;
    exp_bank = 2'h0;
    run_row(rows[25], 8'h00, 16'h0400, 2'h0);
    $display("mid-run reset done");
    final_report();
  end
endmodule
